// file: src/comparator_control_wrapper.sv
/*
 Control and status wrapper of an analog comparator, reached over APB.
 Assumes the analog core returns its raw result on compare_raw, that sleep_mode
 comes from the power controller, and that clk_request_n low means some other
 block still requests the peripheral clock while in standby.
*/
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`include "comparator_cfg.svh"

// Behaviour
// - Edge field picks any, falling or rising edges for the flag.
// - In standby with run bit, comparator runs; flag and status freeze unless clk_request_n is low.
// - Pad output carries the result only while pad enable is set.
// - Low-power bit is forwarded to the analog core.
// - Hysteresis field is forwarded to the analog core.
// - Enable bit turns the comparator on; zero keeps it off.
// - Invert bit flips the result for every consumer.
// - Positive select picks one of four positive pins.
// - Negative select picks pin 0, pin 1, reference or converter output.
// - Interrupt enable bit 0 gates the interrupt request.
// - Status bit 4 shows the result after a three-stage synchroniser.
// - Status bit 0 is the flag; writing one clears it.
// - Chosen edge on the result sets the flag.
// - Request stays high while flag and enable are both one.
// - Power-down sleep turns off comparator and pad output.
// - Event output is the unclocked result.
module comparator_control_wrapper
   import comparator_pkg::*;
#(
   parameter int ADDR_W = 6,
   parameter int SYNC_DEPTH = `SYNC_STAGES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic compare_raw,
   input wire sleep_mode_t sleep_mode,
   input wire logic clk_request_n,
   output analog_cfg_t analog_cfg,
   output logic compare_event,
   output logic pad_out,
   output logic pad_oe,
   output logic compare_irq
);

   initial begin
      if (ADDR_W < 6) begin
         $error("ADDR_W must cover the register window");
      end
      if (SYNC_DEPTH < 2) begin
         $error("SYNC_DEPTH must be at least 2");
      end
   end

   control_t control_q;
   input_select_t input_select_q;
   logic irq_enable_q;
   logic flag_q;
   logic [SYNC_DEPTH-1:0] sync_q;
   logic state_q;
   logic prev_q;
   logic prev_valid_q;
   logic powered;
   logic result;
   logic freeze;
   logic edge_hit;
   logic wr_en;
   logic [3:0] reg_idx;
   logic idx_ok;
   logic [7:0] rd_byte;

   // Word index from a byte address; misaligned addresses never match
   function automatic logic [3:0] word_index(input logic [ADDR_W-1:0] a);
      return a[5:2];
   endfunction

   assign reg_idx = word_index(paddr);
   assign idx_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:2] < 16);
   // Zero wait state slave: accesses complete in the access phase
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en = psel && penable && pwrite && pstrb[0] && idx_ok;

   assign powered = control_q.enable && (sleep_mode != sleep_power_down)
      && !((sleep_mode == sleep_standby) && !control_q.standby_run);

   assign result = powered && (compare_raw ^ input_select_q.invert);

   assign compare_event = result;

   assign pad_out = control_q.pad_output_enable ? result : 1'b0;
   assign pad_oe = control_q.pad_output_enable && powered;

   assign analog_cfg = '{
      enable: powered,
      low_power_select: control_q.low_power_select,
      hysteresis_select: control_q.hysteresis_select,
      positive_input_select: input_select_q.positive_input_select,
      negative_input_select: input_select_q.negative_input_select
   };

   // clock stopped in standby unless another block asks for it
   assign freeze = (sleep_mode == sleep_standby) && clk_request_n;

   // Synchroniser; only the last stage is looked at
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_q <= '0;
      end else if (!freeze) begin
         sync_q <= {sync_q[SYNC_DEPTH-2:0], result};
      end
   end

   // state bit follows the synchroniser output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= 1'b0;
         prev_q <= 1'b0;
         prev_valid_q <= 1'b0;
      end else if (!freeze) begin
         state_q <= sync_q[SYNC_DEPTH-1];
         prev_q <= state_q;
         prev_valid_q <= 1'b1;
      end
   end

   // edges on synchronised result, reserved value gives none
   // edge kind chosen by the field
   always_comb begin
      edge_hit = 1'b0;
      if (prev_valid_q) begin
         case (control_q.edge_select)
            any_edge: edge_hit = state_q ^ prev_q;
            falling_edge: edge_hit = prev_q && !state_q;
            rising_edge: edge_hit = !prev_q && state_q;
            default: edge_hit = 1'b0;
         endcase
      end
   end

   // set wins over a simultaneous clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 1'b0;
      end else if (edge_hit && !freeze) begin
         flag_q <= 1'b1;
      end else if (wr_en && pwdata[`ST_FLAG] &&
                   (reg_idx == `IDX_STATUS || reg_idx == `IDX_STATUS_CLEAR)) begin
         flag_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_q <= control_t'(`RST_CONTROL);
         input_select_q <= input_select_t'(`RST_INPUT_SELECT);
         irq_enable_q <= 1'b0;
      end else if (wr_en) begin
         case (reg_idx)
            `IDX_CONTROL: control_q <= control_t'(pwdata[7:0] & `MASK_CONTROL);
            `IDX_INPUT_SELECT:
               input_select_q <= input_select_t'(pwdata[7:0] & `MASK_INPUT_SELECT);
            `IDX_IRQ_ENABLE: irq_enable_q <= pwdata[0];
            default: ;
         endcase
      end
   end

   assign compare_irq = flag_q && irq_enable_q;

   always_comb begin
      rd_byte = 8'h00;
      if (idx_ok) begin
         case (reg_idx)
            `IDX_CONTROL: rd_byte = control_q;
            `IDX_INPUT_SELECT: rd_byte = input_select_q & `MASK_INPUT_SELECT;
            `IDX_IRQ_ENABLE: rd_byte = {7'h00, irq_enable_q};
            `IDX_STATUS: rd_byte = {3'h0, state_q, 3'h0, flag_q};
            default: rd_byte = 8'h00;
         endcase
      end
   end

   // Read data registered in the setup phase, valid during access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {24'h00_0000, rd_byte};
      end
   end

endmodule // comparator_control_wrapper

// file: src/comparator_cfg.svh
/*
 Register offsets, field positions and reset values of the comparator wrapper.
 Assumes inclusion from the package and the top module only.
*/
`ifndef COMPARATOR_CFG_SVH
`define COMPARATOR_CFG_SVH

// Printed offsets are not all multiples of four: these are indices
`define IDX_CONTROL 4'h0
`define IDX_INPUT_SELECT 4'h2
`define IDX_IRQ_ENABLE 4'h6
`define IDX_STATUS 4'h7
// Clear register for the status word, same layout
`define IDX_STATUS_CLEAR 4'h8

`define RST_CONTROL 8'h00
`define RST_INPUT_SELECT 8'h00
`define RST_IRQ_ENABLE 8'h00

// Control fields
`define CTL_ENABLE 0
`define CTL_HYST_LO 1
`define CTL_LOW_POWER 3
`define CTL_EDGE_LO 4
`define CTL_PAD_OUT 6
`define CTL_STBY_RUN 7
// Input select fields
`define MUX_NEG_LO 0
`define MUX_POS_LO 3
`define MUX_INVERT 7
// Status fields
`define ST_FLAG 0
`define ST_STATE 4

// Writable bit masks
`define MASK_CONTROL 8'hFF
`define MASK_INPUT_SELECT 8'h9B
`define MASK_IRQ_ENABLE 8'h01

// Synchroniser depth for the state bit
`define SYNC_STAGES 3

`endif

// file: src/comparator_pkg.sv
/*
 Types shared by the comparator wrapper.
 Assumes the configuration header is available by bare name.
*/
package comparator_pkg;
`include "comparator_cfg.svh"

   typedef enum logic [1:0] {
      any_edge = 2'h0,
      edge_reserved = 2'h1,
      falling_edge = 2'h2,
      rising_edge = 2'h3
   } edge_select_t;

   typedef struct packed {
      logic standby_run;
      logic pad_output_enable;
      edge_select_t edge_select;
      logic low_power_select;
      logic [1:0] hysteresis_select;
      logic enable;
   } control_t;

   typedef struct packed {
      logic invert;
      logic [1:0] spare;
      logic [1:0] positive_input_select;
      logic spare2;
      logic [1:0] negative_input_select;
   } input_select_t;

   // Settings handed to the analog core
   typedef struct packed {
      logic enable;
      logic low_power_select;
      logic [1:0] hysteresis_select;
      logic [1:0] positive_input_select;
      logic [1:0] negative_input_select;
   } analog_cfg_t;

   typedef enum logic [1:0] {
      sleep_active = 2'h0,
      sleep_idle = 2'h1,
      sleep_standby = 2'h3,
      sleep_power_down = 2'h2
   } sleep_mode_t;
endpackage

// file: dv/comparator_props.sv
/*
 Port-level assertions for the comparator wrapper.
 Assumes a single clock domain and binding onto the wrapper's top module.
*/
`timescale 1ns/1ns
module comparator_props
   import comparator_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   input wire logic compare_raw,
   input wire sleep_mode_t sleep_mode,
   input wire logic clk_request_n,
   input wire analog_cfg_t analog_cfg,
   input wire logic compare_event,
   input wire logic pad_out,
   input wire logic pad_oe,
   input wire logic compare_irq
);
   logic wr;
   // Completed write; the only allowed cause of a compare_irq fall and, with a sleep mode change, of an analog_cfg change
   assign wr = psel & penable & pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_pad_result: assert property (pad_out == (pad_oe & compare_event))
      else $error("pad output disagrees with result");
   a_off_quiet: assert property (!analog_cfg.enable |-> !compare_event && !pad_oe)
      else $error("result visible while core off");
   a_power_down: assert property (sleep_mode == sleep_power_down |->
      !analog_cfg.enable && !pad_oe)
      else $error("core or pad alive in power-down");
   a_event_follow: assert property (analog_cfg.enable && $past(analog_cfg.enable) &&
      $changed(compare_raw) && !$past(wr) |-> $changed(compare_event))
      else $error("event did not follow raw result");
   a_standby_freeze: assert property (sleep_mode == sleep_standby && clk_request_n &&
      $past(sleep_mode) == sleep_standby && $past(clk_request_n) && !$past(wr)
      |-> $stable(compare_irq))
      else $error("request moved with clock stopped");
   a_cfg_written: assert property ($changed(analog_cfg) |-> $past(wr) ||
      $changed(sleep_mode))
      else $error("analog settings changed unprompted");
   a_irq_hold: assert property ($fell(compare_irq) |-> $past(wr))
      else $error("request dropped without a write");
   a_rdata_upper: assert property (prdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
   a_ready_ok: assert property (pready && !pslverr)
      else $error("slave stalled or flagged error");
endmodule // comparator_props

bind comparator_control_wrapper comparator_props props (.pclk, .presetn, .psel, .penable,
   .pwrite, .pready, .pslverr, .prdata, .compare_raw, .sleep_mode, .clk_request_n,
   .analog_cfg, .compare_event, .pad_out, .pad_oe, .compare_irq);

// file: dv/analog_core_model.sv
/*
 Behavioural stand-in for the analog comparator core.
 Assumes the bench sets the input difference sign on level.
*/
`timescale 1ns/1ns
module analog_core_model
   import comparator_pkg::*;
(
   input wire logic pclk,
   input wire analog_cfg_t analog_cfg,
   input wire logic level,
   output logic compare_raw
);
   logic junk_q = 1'b0;
   // Unpowered core has no valid result, so it shows a changing pattern
   always_ff @(posedge pclk) begin
      junk_q <= ~junk_q;
   end
   assign compare_raw = analog_cfg.enable ? level : junk_q;
endmodule // analog_core_model

// file: dv/comparator_control_wrapper_bench.sv
/*
 Self-checking bench for the comparator wrapper.
 Assumes the APB slave answers at once and the analog core model beside it.
*/
`timescale 1ns/1ns
module comparator_control_wrapper_bench;
   import comparator_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lvl = 0, clk_request_n = 1;
   logic [5:0] paddr = 6'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, compare_raw, compare_event, pad_out, pad_oe, compare_irq;
   sleep_mode_t sleep_mode = sleep_active;
   analog_cfg_t analog_cfg;
   int err_total = 0, cmp_count = 0, m;
   logic [7:0] v;
   logic [5:0] adr [5] = '{6'h00, 6'h08, 6'h18, 6'h1C, 6'h04};
   always #10 pclk = ~pclk;
   comparator_control_wrapper DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .compare_raw, .sleep_mode,
      .clk_request_n, .analog_cfg, .compare_event, .pad_out, .pad_oe, .compare_irq);
   analog_core_model core (.pclk, .analog_cfg, .level(lvl), .compare_raw);
   task report_and_stop;
      $display("errors %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // One APB transfer; waits for pready under a bound
   task apb(input logic w, input logic [5:0] a, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         err_total++;
         report_and_stop;
      end
      r = prdata;
      psel <= 0;
      penable <= 0;
      #1;
   endtask
   task settle;
      repeat (8) @(posedge pclk);
      #1;
   endtask
   initial begin
      void'($urandom(97542));
      repeat (12) @(posedge pclk);
      presetn <= 1;
      apb(1, 6'h04, 8'hFF);
      for (m = 0; m < 5; m++) begin
         apb(0, adr[m], 8'h00);
         chk(r, 0);
      end
      v = $urandom;
      apb(1, 6'h00, v);
      apb(0, 6'h00, 8'h00);
      chk(r, v);
      chk({analog_cfg.low_power_select, analog_cfg.hysteresis_select}, v[3:1]);
      v = $urandom;
      apb(1, 6'h08, v & 8'h1B);
      apb(0, 6'h08, 8'h00);
      chk(r, v & 8'h1B);
      chk({analog_cfg.positive_input_select, analog_cfg.negative_input_select},
         {v[4:3], v[1:0]});
      apb(1, 6'h18, 8'h01);
      for (m = 0; m < 4; m++) begin
         apb(1, 6'h00, 8'h41 | (m << 4));
         apb(1, 6'h20, 8'h01);
         @(posedge pclk) lvl <= 1;
         settle;
         apb(0, 6'h1C, 8'h00);
         chk(r[4], 1);
         chk(compare_irq, m == 0 || m == 3);
         chk(pad_out, 1);
         apb(1, 6'h1C, 8'h00);
         chk(compare_irq, m == 0 || m == 3);
         apb(1, 6'h1C, 8'h01);
         chk(compare_irq, 0);
         @(posedge pclk) lvl <= 0;
         settle;
         chk(compare_irq, m == 0 || m == 2);
      end
      apb(1, 6'h18, 8'h00);
      apb(1, 6'h08, 8'h80);
      chk(compare_event, 1);
      settle;
      apb(0, 6'h1C, 8'h00);
      chk(r[0], 1);
      chk(compare_irq, 0);
      apb(1, 6'h18, 8'h01);
      chk(compare_irq, 1);
      apb(1, 6'h00, 8'hF1);
      @(posedge pclk) lvl <= 1;
      settle;
      apb(1, 6'h20, 8'h01);
      @(posedge pclk) sleep_mode <= sleep_standby;
      @(posedge pclk) lvl <= 0;
      settle;
      chk(compare_event, 1);
      chk(compare_irq, 0);
      @(posedge pclk) sleep_mode <= sleep_active;
      settle;
      chk(compare_irq, 1);
      // Standby with the clock kept alive by another block: edges still count
      apb(1, 6'h20, 8'h01);
      @(posedge pclk) begin
         sleep_mode <= sleep_standby;
         clk_request_n <= 0;
         lvl <= 1;
      end
      settle;
      chk(compare_irq, 0);
      @(posedge pclk) lvl <= 0;
      settle;
      chk(compare_irq, 1);
      @(posedge pclk) sleep_mode <= sleep_power_down;
      settle;
      chk({pad_oe, analog_cfg.enable}, 0);
      report_and_stop;
   end
endmodule // comparator_control_wrapper_bench
